// file: rtl/ctg_timing_gen.sv
// Timing generator top: prescaler, divider, main clock, machine cycles.
// Assumes both oscillator clocks arrive as slow square-wave levels on pins
// and a mode controller drives the control struct on the system clock.
// STOP entry and exit clear the chain, so the mode must be held
// for at least one clock on each side of STOP.
// Derived source clocks are one-cycle enables, not real clocks.
`timescale 1ns/100ps
`default_nettype none
module ctg_timing_gen import ctg_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       highFreqOscIn,
  input  wire logic       lowFreqOscIn,
  input  wire ctg_ctrl_s  ctrl,
  input  wire logic [3:0] insnLength,
  output ctg_out_s        timing,
  output logic            dividerOutputPulse,
  output logic            timeBaseClock,
  output logic            watchdogClock,
  output logic            timerSourceClock,
  output logic            warmupClock
);

  // Each oscillator pin is asynchronous to clock, so only a
  // single-cycle rising-edge tick ever reaches the chain.
  // Basic clock edges, synchronised
  logic fcTick;
  logic fsTick;

  ctg_edge_sync u_fc_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .asyncIn   (highFreqOscIn),
    .risePulse (fcTick)
  ); // [R12]


  // Slow oscillator uses the same three-flop filter
  ctg_edge_sync u_fs_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .asyncIn   (lowFreqOscIn),
    .risePulse (fsTick)
  ); // [R12]


  // The clear must cover the edge into and out of STOP, so the
  // registered level is compared with the present one.
  // STOP entry and exit detection
  logic stopLevel;
  logic stop_reg;
  logic stop_next;
  logic stopChange;


  // Level and change of the STOP request
  assign stopLevel  = (ctrl.mode == CTG_STOP);
  assign stopChange = stopLevel ^ stop_reg;


  // Next STOP level is the present one
  always_comb begin
    stop_next = stopLevel;
  end


  // Last cycle's STOP level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= stop_next;
    end
  end


  // A function keeps the low-speed decode in one place
  // Mode decode helper, used by several selections
  function automatic logic isLowSpeed(input ctg_mode_e m);
    return (m == CTG_SLOW) || (m == CTG_SLEEP);
  endfunction

  // Decoded mode and the chain clear
  logic lowSpeed;
  logic clearChain;
  assign lowSpeed   = isLowSpeed(ctrl.mode);
  assign clearChain = stopChange | stopLevel; // [R3]


  // The prescaler only counts while the fast clock may reach the
  // chain; its carry is the first divider stage's input.
  // Clearing it with the divider keeps the stage phases aligned.
  // Two-stage prescaler on the high-frequency clock
  logic [PRESCALE_STAGES-1:0] pre_reg;
  logic [PRESCALE_STAGES-1:0] pre_next;
  logic                       preOut;
  logic                       fcGated;


  // Fast ticks are blocked in low-speed modes
  assign fcGated = fcTick & ~lowSpeed; // [R14]
  assign preOut  = fcGated & (&pre_reg);


  // Count fast ticks; clearing wins over counting
  always_comb begin
    if (clearChain) begin
      pre_next = PRESCALE_RESET; // [R3]
    end else if (fcGated) begin
      pre_next = pre_reg + 2'h1; // [R1]
    end else begin
      pre_next = pre_reg;
    end
  end


  // Prescaler register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= PRESCALE_RESET; // [R3]
    end else begin
      pre_reg <= pre_next;
    end
  end


  // Priority: low-speed modes, then warm-up from normal, then the select
  // bit, which is honoured only in dual clock mode.
  // Divider input routing, stage seven by mode and select bits
  logic [DIV_STAGES-1:0] divBits;
  logic [DIV_STAGES-1:0] divTick;
  logic [DIV_STAGES-1:0] stageIn;
  logic                  stage7Src;

  always_comb begin
    if (lowSpeed) begin
      stage7Src = fsTick; // [R6]
    end else if (ctrl.mode == CTG_WARMUP && ctrl.warmupFromNormal) begin
      stage7Src = divTick[STAGE7_IDX-1]; // [R7]
    end else if (ctrl.stage7ClockSelect && ctrl.dualClockMode) begin
      stage7Src = fsTick; // [R2] [R4] [R5]
    end else begin
      stage7Src = divTick[STAGE7_IDX-1]; // [R2]
    end
  end


  // Stage inputs: prescaler carry, then ripple of ticks
  always_comb begin
    stageIn = '0;
    stageIn[0] = preOut & ~lowSpeed; // [R14]
    for (int k = 1; k < DIV_STAGES; k++) begin
      stageIn[k] = (k == STAGE7_IDX) ? stage7Src : divTick[k-1]; // [R16]
    end
  end


  // Ripple chain of enable-driven stages
  ctg_divider u_div (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (clearChain),
    .stageIn (stageIn),
    .bits    (divBits),
    .tick    (divTick)
  ); // [R1]


  // Ticks are suppressed in STOP so the machine cycle freezes
  // together with the oscillators.
  // Main system clock tick: fc or fs by the source select
  logic mainTick;
  assign mainTick = ~stopLevel &
                    (ctrl.mainClockSourceSelect ? fsTick : fcTick); // [R13] [R15]


  // Sequencer state and machine cycle count
  // Machine cycle state sequencer
  ctg_state_e state_reg;
  ctg_state_e state_next;
  logic [3:0] mc_reg;
  logic [3:0] mc_next;
  logic [3:0] lenClamped;
  logic       cycEnd;
  logic       insEnd;


  // Out-of-range lengths are clamped rather than refused, so a bad
  // length can never stall the instruction end pulse.
  always_comb begin
    if (insnLength < INSN_LEN_MIN) begin
      lenClamped = INSN_LEN_MIN;
    end else if (insnLength > INSN_LEN_MAX) begin
      lenClamped = INSN_LEN_MAX;
    end else begin
      lenClamped = insnLength; // [R9]
    end
  end


  // Gray stepping, one state per main clock tick
  always_comb begin
    state_next = state_reg;
    cycEnd     = 1'b0;
    if (mainTick) begin
      unique case (state_reg)
        CTG_S0: state_next = CTG_S1; // [R8]
        CTG_S1: state_next = CTG_S2;
        CTG_S2: state_next = CTG_S3;
        CTG_S3: begin
          state_next = CTG_S0;
          cycEnd     = 1'b1;
        end
      endcase
    end
  end


  // Counts machine cycles; instruction ends at the clamped length
  always_comb begin
    mc_next = mc_reg;
    insEnd  = 1'b0;
    if (cycEnd) begin
      if (mc_reg + 4'h1 >= lenClamped) begin
        mc_next = 4'h0; // [R9]
        insEnd  = 1'b1;
      end else begin
        mc_next = mc_reg + 4'h1;
      end
    end
  end


  // Sequencer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CTG_S0;
      mc_reg    <= 4'h0;
    end else begin
      state_reg <= state_next;
      mc_reg    <= mc_next;
    end
  end

  // Registered outputs for core, peripherals and derived clocks
  ctg_out_s timing_reg;
  ctg_out_s timing_next;
  logic     dvo_reg;
  logic     dvo_next;
  logic     tb_reg;
  logic     tb_next;
  logic     wd_reg;
  logic     wd_next;
  logic     tmr_reg;
  logic     tmr_next;
  logic     wu_reg;
  logic     wu_next;

  // Core and peripheral enables share one main tick
  always_comb begin
    timing_next.mainClockTick = mainTick; // [R10]
    timing_next.state         = state_next; // [R8]
    timing_next.cycleEnd      = cycEnd;
    timing_next.insnEnd       = insEnd;
    timing_next.dividerTaps   = divTick; // [R11]
  end

  // Derived source clocks are single-cycle stage ticks
  always_comb begin
    dvo_next = divTick[DVO_TAP_IDX];  // [R11] Divider output pulse
    tb_next  = divTick[DIV_STAGES-1]; // Time base source
    wd_next  = divTick[DIV_STAGES-1]; // Watchdog source
    tmr_next = divTick[STAGE7_IDX];   // Timer/counter source
    wu_next  = divTick[DIV_STAGES-1]; // Warm-up count clock
  end

  // Every output leaves from a flip-flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timing_reg <= '0;
      dvo_reg    <= 1'b0;
      tb_reg     <= 1'b0;
      wd_reg     <= 1'b0;
      tmr_reg    <= 1'b0;
      wu_reg     <= 1'b0;
    end else begin
      timing_reg <= timing_next;
      dvo_reg    <= dvo_next;
      tb_reg     <= tb_next;
      wd_reg     <= wd_next;
      tmr_reg    <= tmr_next;
      wu_reg     <= wu_next;
    end
  end

  // Top-level outputs
  assign timing             = timing_reg;
  assign dividerOutputPulse = dvo_reg;
  assign timeBaseClock      = tb_reg;
  assign watchdogClock      = wd_reg;
  assign timerSourceClock   = tmr_reg;
  assign warmupClock        = wu_reg;
endmodule // ctg_timing_gen
`default_nettype wire

// file: rtl/ctg_pkg.sv
// Shared constants and types for the clock timing generator.
// Assumes one 10 MHz system clock; oscillator clocks arrive as sampled levels.
// Operation
// R1 - Two-stage prescaler, 21-stage divider, cycle counters
// R2 - Stage-seven input chosen by mode and selects
// R3 - Clear chain on reset, STOP entry, exit
// R4 - Software keeps stage7 select low in single mode
// R5 - Stage7 select set only after slow oscillator stable
// R6 - Low-speed modes feed stage seven from slow clock
// R7 - Warm-up from normal feeds stage seven from six
// R8 - Machine cycle has four one-clock states
// R9 - Instructions last one to ten machine cycles
// R10 - Core and peripherals share main clock enable
// R11 - Provide main, divider, timer and warm-up clocks
// R12 - Two independent basic clocks feed everything
// R13 - Source select one picks slow clock
// R14 - Low-speed modes stop divider stages one-six
// R15 - Machine cycle is four basic clock periods
// R16 - Each stage halves its predecessor's rate
package ctg_pkg;
  localparam int PRESCALE_STAGES = 2;
  localparam int DIV_STAGES      = 21;
  localparam int STAGE7_IDX      = 6;   // Zero-based index of stage seven
  localparam int DVO_TAP_IDX     = 12;  // Stage tick that drives the divider output pulse
  localparam int STATES_PER_MC   = 4;
  localparam int MAX_INSN_CYCLES = 10;
  localparam logic [3:0] INSN_LEN_MIN = 4'h1;
  localparam logic [3:0] INSN_LEN_MAX = 4'hA;
  localparam logic [PRESCALE_STAGES-1:0] PRESCALE_RESET = '0;
  localparam logic [DIV_STAGES-1:0]      DIV_RESET      = '0;

  // Operating mode as reported by the mode controller
  typedef enum logic [2:0] {
    CTG_NORMAL = 3'h0,
    CTG_SLOW   = 3'h1,
    CTG_SLEEP  = 3'h3,
    CTG_IDLE   = 3'h2,
    CTG_STOP   = 3'h6,
    CTG_WARMUP = 3'h7
  } ctg_mode_e;

  // Machine cycle states, Gray coded
  typedef enum logic [1:0] {
    CTG_S0 = 2'h0,
    CTG_S1 = 2'h1,
    CTG_S2 = 2'h3,
    CTG_S3 = 2'h2
  } ctg_state_e;

  // Control inputs grouped together
  typedef struct packed {
    ctg_mode_e  mode;
    logic       dualClockMode;
    logic       mainClockSourceSelect;
    logic       stage7ClockSelect;
    logic       warmupFromNormal;
  } ctg_ctrl_s;

  // Clock enables handed to the core and peripherals
  typedef struct packed {
    logic                  mainClockTick;
    ctg_state_e            state;
    logic                  cycleEnd;
    logic                  insnEnd;
    logic [DIV_STAGES-1:0] dividerTaps;
  } ctg_out_s;
endpackage : ctg_pkg

// file: rtl/ctg_edge_sync.sv
// Three-flop synchroniser producing a rising-edge pulse.
// Assumes the input is asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module ctg_edge_sync import ctg_pkg::*; (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      risePulse
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  // Shift chain; first flop feeds only the second
  always_comb begin
    sync_next = {sync_reg[1:0], asyncIn};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Change counted once stages two and three disagree toward high
  assign risePulse = sync_reg[1] & ~sync_reg[2];
endmodule // ctg_edge_sync
`default_nettype wire

// file: rtl/ctg_divider.sv
// Enable-based binary divider chain with per-stage tick outputs.
// Assumes stage ticks are consumed as one-cycle enables on clock.
`timescale 1ns/100ps
`default_nettype none
module ctg_divider import ctg_pkg::*; #(
  parameter int N = DIV_STAGES
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic [N-1:0] stageIn,
  output logic [N-1:0]      bits,
  output logic [N-1:0]      tick
);
  logic [N-1:0] bits_reg;
  logic [N-1:0] bits_next;

  // Each stage toggles on its input tick; a falling output ticks the next
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      always_comb begin
        bits_next[i] = clear ? 1'b0 : (bits_reg[i] ^ stageIn[i]); // [R16] [R3]
      end
      assign tick[i] = ~clear & stageIn[i] & bits_reg[i];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bits_reg <= '0; // [R3]
    end else begin
      bits_reg <= bits_next;
    end
  end

  assign bits = bits_reg;
endmodule // ctg_divider
`default_nettype wire

// file: bench/ctg_timing_gen_properties.sv
// Port checker for the clock timing generator.
// Assumes it is bound onto ctg_timing_gen.
`timescale 1ns/100ps
`default_nettype none
module ctg_timing_gen_properties import ctg_pkg::*; (
  input wire logic      clock,
  input wire logic      rst_b,
  input wire logic      highFreqOscIn,
  input wire logic      lowFreqOscIn,
  input wire ctg_ctrl_s ctrl,
  input wire ctg_out_s  timing,
  input wire logic      dividerOutputPulse,
  input wire logic      timeBaseClock,
  input wire logic      watchdogClock,
  input wire logic      timerSourceClock,
  input wire logic      warmupClock
);
  // Low-speed modes
  wire logic lowSpd = ctrl.mode == CTG_SLOW || ctrl.mode == CTG_SLEEP;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Chain, machine cycle and output pulse relations
  property p_rstClear; $rose(rst_b) |-> timing == '0; endproperty
  a_rstClear: assert property (p_rstClear) else $error("outputs not clear after reset");
  property p_stopClear; (ctrl.mode == CTG_STOP)[*3] |-> timing.dividerTaps == '0; endproperty
  a_stopClear: assert property (p_stopClear) else $error("divider ticks in stop");
  property p_lowStop; lowSpd[*3] |-> timing.dividerTaps[5:0] == '0; endproperty
  a_lowStop: assert property (p_lowStop) else $error("early stages run in low speed");
  property p_fcTick;
    $rose(highFreqOscIn) ##2 (!ctrl.mainClockSourceSelect && ctrl.mode == CTG_NORMAL) |=> timing.mainClockTick;
  endproperty
  a_fcTick: assert property (p_fcTick) else $error("fast main tick missing");
  property p_fsTick;
    $rose(lowFreqOscIn) ##2 (ctrl.mainClockSourceSelect && ctrl.mode == CTG_SLOW) |=> timing.mainClockTick;
  endproperty
  a_fsTick: assert property (p_fsTick) else $error("slow main tick missing");
  property p_grayStep;
    timing.mainClockTick |-> timing.state == {$past(timing.state[0]), !$past(timing.state[1])};
  endproperty
  a_grayStep: assert property (p_grayStep) else $error("state order wrong");
  property p_stateHold;
    (ctrl.mode == CTG_NORMAL)[*3] ##0 !timing.mainClockTick |-> $stable(timing.state);
  endproperty
  a_stateHold: assert property (p_stateHold) else $error("state moved without tick");
  property p_pulseOne; dividerOutputPulse |=> !dividerOutputPulse; endproperty
  a_pulseOne: assert property (p_pulseOne) else $error("divider pulse too long");
  property p_tmrTap; timerSourceClock == timing.dividerTaps[STAGE7_IDX]; endproperty
  a_tmrTap: assert property (p_tmrTap) else $error("timer source not stage seven tick");
  property p_dvoTap; dividerOutputPulse == timing.dividerTaps[DVO_TAP_IDX]; endproperty
  a_dvoTap: assert property (p_dvoTap) else $error("divider pulse not its stage tick");
  property p_lastTap;
    {timeBaseClock, watchdogClock, warmupClock} == {3{timing.dividerTaps[DIV_STAGES-1]}};
  endproperty
  a_lastTap: assert property (p_lastTap) else $error("timer clocks not last stage tick");
endmodule // ctg_timing_gen_properties
bind ctg_timing_gen ctg_timing_gen_properties u_props (.clock, .rst_b, .highFreqOscIn, .lowFreqOscIn,
  .ctrl, .timing, .dividerOutputPulse, .timeBaseClock, .watchdogClock, .timerSourceClock, .warmupClock);
`default_nettype wire

// file: bench/ctg_core_model.sv
// Core and peripheral timer side: counts the enables it receives.
// Assumes every pulse on timing lasts one clock.
`timescale 1ns/100ps
`default_nettype none
module ctg_core_model import ctg_pkg::*; (
  input  wire logic     clock,
  input  wire logic     rst_b,
  input  wire ctg_out_s timing,
  output var int        cnt [8]
);
  // Events: tick, cycle end, insn end, tap0, tap1, tap6, any early tap, any tap
  wire logic [7:0] ev = {|timing.dividerTaps, |timing.dividerTaps[5:0], timing.dividerTaps[6],
                         timing.dividerTaps[1:0], timing.insnEnd, timing.cycleEnd, timing.mainClockTick};
  // Everything steps only on the shared enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '{default: 0};
    end else begin
      for (int i = 0; i < 8; i++) cnt[i] <= cnt[i] + int'(ev[i]);
    end
  end
endmodule // ctg_core_model
`default_nettype wire

// file: bench/ctg_timing_gen_test.sv
// Self-checking bench for the timing generator.
// Assumes fc is 8 clocks and fs 40 clocks per period.
`timescale 1ns/100ps
`default_nettype none
module ctg_timing_gen_test import ctg_pkg::*;;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       hfOsc = 1'b0;
  logic       lfOsc = 1'b0;
  logic [3:0] insnLength = INSN_LEN_MIN;
  ctg_ctrl_s  ctrl = '{mode: CTG_NORMAL, default: 1'b0};
  ctg_out_s   timing;
  int         cnt [8];
  int         base [8];
  int         fail_count = 0;
  int         tests_run = 0;
  int         cycles = 0;
  ctg_timing_gen u_dut (.clock, .rst_b, .highFreqOscIn(hfOsc), .lowFreqOscIn(lfOsc), .ctrl, .insnLength,
    .timing, .dividerOutputPulse(), .timeBaseClock(), .watchdogClock(), .timerSourceClock(), .warmupClock());
  ctg_core_model u_core (.clock, .rst_b, .timing, .cnt);
  // Clock
  initial forever #50 clock = ~clock;
  // Oscillator levels and run limit
  always @(negedge clock) begin
    cycles <= cycles + 1;
    hfOsc <= cycles[2];
    lfOsc <= (cycles % 40) >= 20;
    if (cycles > 30000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits n cycles, counting events from the start
  task automatic span(input int n);
    base = cnt;
    repeat (n) @(negedge clock);
  endtask
  function automatic logic [31:0] d(input int i);
    return cnt[i] - base[i];
  endfunction
  task automatic setMode(input ctg_mode_e m, input logic sel, input logic s7);
    ctrl.mode = m;
    ctrl.mainClockSourceSelect = sel;
    ctrl.stage7ClockSelect = s7;
    span(200);
  endtask
  task automatic t_fast();
    span(640);
    check(d(0), 80);
    check(d(1), 20);
    check(d(3), 10);
    check(d(4), 5);
    insnLength = INSN_LEN_MAX;
    span(352);
    span(960);
    check(d(2), 3);
  endtask
  task automatic t_slow();
    ctrl.dualClockMode = 1'b1;
    ctrl.warmupFromNormal = 1'b1;
    setMode(CTG_SLOW, 1'b1, 1'b0);
    span(800);
    check(d(0), 20);
    check(d(1), 5);
    check(d(5), 10);
    check(d(6), 0);
    setMode(CTG_SLEEP, 1'b1, 1'b1);
    span(800);
    check(d(5), 10);
    check(d(6), 0);
  endtask
  // Select bit set only in dual mode with fs long running
  task automatic t_select();
    setMode(CTG_NORMAL, 1'b0, 1'b1);
    span(800);
    check(d(5), 10);
    check(d(0), 100);
    setMode(CTG_WARMUP, 1'b0, 1'b1);
    span(800);
    check(32'(d(5) <= 1), 1);
  endtask
  task automatic t_stop();
    setMode(CTG_NORMAL, 1'b0, 1'b0);
    ctrl.mode = CTG_STOP;
    span(5);
    span(100);
    check(d(7), 0);
    ctrl.mode = CTG_NORMAL;
    span(48);
    check(d(3), 0);
  endtask
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    check(32'(timing), 0);
    t_fast();
    t_slow();
    t_select();
    t_stop();
    summarize();
  end
endmodule // ctg_timing_gen_test
`default_nettype wire
